/* pmc_consts.vh */
// Constants for the positioning mode arbiter and command input front end
`ifndef PMC_CONSTS_VH
`define PMC_CONSTS_VH

// Clock rate and jog hold time
`define PMC_CLK_HZ          100000000
`define PMC_JOG_HOLD_MS     100
`define PMC_JOG_HOLD_CYC    ((`PMC_CLK_HZ / 1000) * `PMC_JOG_HOLD_MS)
`define PMC_JOG_CNT_W       24

// Designated general-purpose mode input bit per variant
`define PMC_MODE_BIT_SINGLE 3
`define PMC_MODE_BIT_DUAL   7
`define PMC_GPI_W           8

// Stop mode parameter width (values 0 to 7)
`define PMC_STOP_MODE_W     3

// Program halt codes
`define PMC_MCODE_W         8
`define PMC_PAUSE_CODE      8'h00
`define PMC_END_CODE        8'h02

// Program run states, one-hot
`define PMC_ST_W            3
`define PMC_ST_IDLE         3'h1
`define PMC_ST_RUN          3'h2
`define PMC_ST_DRAIN        3'h4

`endif

/* pmc_gen_model.sv */
// Pulse generator stand-in that answers the command front end
`timescale 1ns/100ps
module pmc_gen_model #(
  parameter ZR_CYC = 6
) (
  input  wire i_clk,
  input  wire i_pulse_en,
  input  wire i_zr_cmd,
  output reg  o_pulsing,
  output reg  o_zr_done
);
  reg [3:0] cnt_q;
  // Pulses follow the permit a cycle late; zero return ends after a fixed run
  always @(posedge i_clk) begin
    o_pulsing <= i_pulse_en;
    cnt_q     <= i_zr_cmd ? cnt_q + 4'h1 : 4'h0;
    o_zr_done <= i_zr_cmd && cnt_q == ZR_CYC;
  end
endmodule

/* pmc_mode_cmd.v */
// Mode arbiter and command input front end of a pulse-train positioning unit
`timescale 1ns/100ps
`include "pmc_consts.vh"

module pmc_mode_cmd #(
  parameter DUAL_AXIS     = 0,
  parameter JOG_HOLD_CYC  = `PMC_JOG_HOLD_CYC
) (
  // Clock and reset
  input  wire                         i_core_clk,
  input  wire                         i_rst,
  // Mode sources
  input  wire                         i_panel_manual,
  input  wire                         i_input_mode_enable_flag,
  input  wire                         i_host_manual_request_flag,
  input  wire [`PMC_GPI_W-1:0]        i_gpi,
  // Command inputs
  input  wire                         i_start,
  input  wire                         i_stop,
  input  wire                         i_zero_return_input,
  input  wire                         i_forward_jog_input,
  input  wire                         i_reverse_jog_input,
  input  wire [`PMC_STOP_MODE_W-1:0]  i_stop_mode_parameter,
  // Pulse generator and program status
  input  wire                         i_move_busy,
  input  wire                         i_pulsing,
  input  wire                         i_error,
  input  wire                         i_zero_return_done,
  input  wire                         i_mcode_valid,
  input  wire [`PMC_MCODE_W-1:0]      i_mcode,
  input  wire                         i_prog_at_end,
  // Outputs
  output reg                          o_manual_mode,
  output reg                          o_prog_run,
  output reg                          o_subtask_run,
  output reg                          o_wait_end,
  output reg                          o_auto_pulse_en,
  output reg                          o_start_cmd,
  output reg                          o_stop_cmd,
  output reg  [`PMC_STOP_MODE_W-1:0]  o_stop_mode,
  output reg                          o_zero_return_cmd,
  output reg                          o_fwd_step,
  output reg                          o_fwd_cont,
  output reg                          o_rev_step,
  output reg                          o_rev_cont,
  output reg                          o_ready
);

  localparam integer MODE_BIT = DUAL_AXIS ? `PMC_MODE_BIT_DUAL : `PMC_MODE_BIT_SINGLE;
  // Hold count cut to the counter width on purpose; the default fits in 24 bits
  localparam integer              HOLD_LAST_I = JOG_HOLD_CYC - 1;
  localparam [`PMC_JOG_CNT_W-1:0] HOLD_LAST   = HOLD_LAST_I[`PMC_JOG_CNT_W-1:0];

  localparam [`PMC_ST_W-1:0] ST_IDLE  = `PMC_ST_IDLE;
  localparam [`PMC_ST_W-1:0] ST_RUN   = `PMC_ST_RUN;
  localparam [`PMC_ST_W-1:0] ST_DRAIN = `PMC_ST_DRAIN;

  ////////////////////////////////////////////////////////////////////////////
  // Block overview
  // Mode sources are levels and are resolved every cycle into manual_d.
  // Command inputs are levels; only their off-to-on edges carry meaning,
  // except stop, whose level also keeps the other commands masked, and the jogs, whose held level gives the continuous run.
  // Every output is registered, so each answer lags its cause by one
  // edge beyond the internal event, and jog outputs by one more.
  // Limitation: the stop behaviour code is only latched and passed on;
  // the pulse generator decides how to decelerate from it.
  // Limitation: zero return and jogs are taken only in manual mode, and
  // start only in automatic mode; an edge in the other mode is dropped,
  // not remembered, so the operator must press again after switching; only a jog held across the switch still gives the continuous run.
  // Trade-off: the jog hold counter is sized for the full hold time at the
  // system clock, which costs 24 flops per lane but needs no prescaler.

  ////////////////////////////////////////////////////////////////////////////
  // Input sampling
  // Inputs are taken as synchronous, so one register stage is enough to
  // get a clean sample; a second stage holds the previous sample so that
  // each edge gives exactly one event cycle.
  // Reset clears both stages to the off level, which matches the idle
  // level of every pin, so no false edge follows reset.
  // An input already on during reset gives one event after release; this
  // is wanted for stop, which then masks every other command from the first cycle.

  reg                   start_q;
  reg                   stop_q;
  reg                   zrn_q;
  reg                   fwd_q;
  reg                   rev_q;
  reg                   stop_prev_q;
  reg                   zrn_prev_q;
  reg                   fwd_prev_q;
  reg                   rev_prev_q;
  reg                   start_prev_q;
  wire                  stop_rise;
  wire                  zrn_rise;
  wire                  fwd_rise;
  wire                  rev_rise;
  wire                  start_rise;

  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      start_q      <= 1'b0;
      stop_q       <= 1'b0;
      zrn_q        <= 1'b0;
      fwd_q        <= 1'b0;
      rev_q        <= 1'b0;
      start_prev_q <= 1'b0;
      stop_prev_q  <= 1'b0;
      zrn_prev_q   <= 1'b0;
      fwd_prev_q   <= 1'b0;
      rev_prev_q   <= 1'b0;
    end else begin
      start_q      <= i_start;
      stop_q       <= i_stop;
      zrn_q        <= i_zero_return_input;
      fwd_q        <= i_forward_jog_input;
      rev_q        <= i_reverse_jog_input;
      start_prev_q <= start_q;
      stop_prev_q  <= stop_q;
      zrn_prev_q   <= zrn_q;
      fwd_prev_q   <= fwd_q;
      rev_prev_q   <= rev_q;
    end
  end

  // One-cycle off-to-on events
  assign start_rise = start_q & ~start_prev_q;
  assign stop_rise  = stop_q & ~stop_prev_q;
  assign zrn_rise   = zrn_q & ~zrn_prev_q;
  assign fwd_rise   = fwd_q & ~fwd_prev_q;
  assign rev_rise   = rev_q & ~rev_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Mode arbitration
  // Pure priority chain; the first true source decides and later ones are
  // never looked at, so a host flag cannot override the panel manual position.
  // The mode input bit is fixed per variant at elaboration time.
  // The result feeds the mode output register and also gates commands
  // directly, so commands switch with the mode in the same cycle that the
  // registered mode output shows it one edge later.

  reg   manual_d;
  wire  gpi_mode = i_gpi[MODE_BIT];

  always @* begin
    if (i_panel_manual) begin
      manual_d = 1'b1;
    end else if (i_host_manual_request_flag) begin
      manual_d = 1'b1;
    end else if (i_input_mode_enable_flag) begin
      manual_d = gpi_mode;
    end else begin
      manual_d = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start, stop and zero-return commands
  // Stop always comes first in each if-chain, so a start or zero-return
  // edge arriving together with a stop edge is lost rather than applied.
  // Halt codes count only while the code is flagged valid, so a stale code
  // left on the bus does not keep clearing a fresh start.
  // The stop command is a single-cycle pulse; the pulse generator keeps
  // its own stopped state from it.

  wire  halt_code = i_mcode_valid &
                    ((i_mcode == `PMC_PAUSE_CODE) | (i_mcode == `PMC_END_CODE));
  wire  ready_d   = ~i_pulsing & ~i_error;

  // Stop held active while the input stays on; it also masks start and jogs
  wire  stop_hold = stop_q;

  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_start_cmd       <= 1'b0;
      o_stop_cmd        <= 1'b0;
      o_stop_mode       <= {`PMC_STOP_MODE_W{1'b0}};
      o_zero_return_cmd <= 1'b0;
      o_ready           <= 1'b0;
      o_auto_pulse_en   <= 1'b0;
    end else begin
      o_stop_cmd <= stop_rise;
      if (stop_rise) begin
        o_stop_mode <= i_stop_mode_parameter;
      end
      // stop and halt codes clear start
      if (stop_rise | stop_hold | halt_code) begin
        o_start_cmd <= 1'b0;
      end else if (start_rise & ~manual_d) begin
        o_start_cmd <= 1'b1;
      end
      // return set and clear; set wins over done
      if (stop_rise | stop_hold) begin
        o_zero_return_cmd <= 1'b0;
      end else if (zrn_rise & manual_d) begin
        o_zero_return_cmd <= 1'b1;
      end else if (i_zero_return_done) begin
        o_zero_return_cmd <= 1'b0;
      end
      o_ready <= ready_d;
      o_auto_pulse_en <= ~manual_d & ready_d & o_start_cmd & ~stop_hold & ~halt_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Jog step and continuous run, one lane per direction
  // Lane 0 is forward and lane 1 is reverse; both are identical.
  // The step comes from the edge event, the continuous run from the hold
  // counter, so a short tap yields exactly one step and no run.
  // The counter parks at its last value instead of wrapping, so a long
  // hold cannot drop the continuous run after a counter overflow.
  // Any of stop, automatic mode or release clears the lane at once.

  wire [1:0] jog_lvl  = {rev_q, fwd_q};
  wire [1:0] jog_rise = {rev_rise, fwd_rise};
  wire [1:0] jog_step;
  wire [1:0] jog_cont;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_jog
      reg [`PMC_JOG_CNT_W-1:0] cnt_q;
      reg                      step_q;
      reg                      cont_q;
      always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
          cnt_q  <= {`PMC_JOG_CNT_W{1'b0}};
          step_q <= 1'b0;
          cont_q <= 1'b0;
        end else if (stop_hold | ~manual_d | ~jog_lvl[g]) begin
          cnt_q  <= {`PMC_JOG_CNT_W{1'b0}};
          step_q <= 1'b0;
          cont_q <= 1'b0;
        end else begin
          step_q <= jog_rise[g];
          if (cnt_q == HOLD_LAST) begin
            cont_q <= 1'b1;
          end else begin
            cnt_q <= cnt_q + {{(`PMC_JOG_CNT_W-1){1'b0}}, 1'b1};
          end
        end
      end
      assign jog_step[g] = step_q;
      assign jog_cont[g] = cont_q;
    end
  endgenerate

  // Registered again so every output comes straight from a flip-flop
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_fwd_step <= 1'b0;
      o_fwd_cont <= 1'b0;
      o_rev_step <= 1'b0;
      o_rev_cont <= 1'b0;
    end else begin
      o_fwd_step <= jog_step[0];
      o_fwd_cont <= jog_cont[0];
      o_rev_step <= jog_step[1];
      o_rev_cont <= jog_cont[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program run control
  // Idle waits for automatic mode, run lets both programs go, and drain
  // lets the move in progress finish after a switch to manual.
  // The subtask program stops at once on the switch; only the main
  // program is allowed to run on until its move completes or it is at its end.
  // The wait flag tells the program side to park at its end instruction.
  // A return to automatic during drain is honoured only after idle, so the
  // program always restarts from a known state.

  reg [`PMC_ST_W-1:0] st_q;

  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q          <= ST_IDLE;
      o_manual_mode <= 1'b1;
      o_prog_run    <= 1'b0;
      o_subtask_run <= 1'b0;
      o_wait_end    <= 1'b0;
    end else begin
      o_manual_mode <= manual_d;
      case (st_q)
        ST_IDLE: begin
          o_wait_end <= 1'b0;
          if (~manual_d) begin
            st_q          <= ST_RUN;
            o_prog_run    <= 1'b1;
            o_subtask_run <= 1'b1;
          end
        end
        ST_RUN: begin
          if (manual_d) begin
            st_q          <= ST_DRAIN;
            o_subtask_run <= 1'b0;
            o_wait_end    <= 1'b1;
          end
        end
        ST_DRAIN: begin
          // Main program stops once the move in progress finishes or the program is at its end
          if (~i_move_busy | i_prog_at_end) begin
            st_q       <= ST_IDLE;
            o_prog_run <= 1'b0;
          end
        end
        default: begin
          st_q          <= ST_IDLE;
          o_prog_run    <= 1'b0;
          o_subtask_run <= 1'b0;
          o_wait_end    <= 1'b0;
        end
      endcase
    end
  end

endmodule

/* pmc_mode_cmd_checker.sv */
// Concurrent checks on the mode arbiter ports
`timescale 1ns/100ps
`include "pmc_consts.vh"
module pmc_mode_cmd_checker #(
  parameter DUAL_AXIS = 0
) (
  input wire       i_core_clk,
  input wire       i_rst,
  input wire       i_panel_manual,
  input wire       i_input_mode_enable_flag,
  input wire       i_host_manual_request_flag,
  input wire [7:0] i_gpi,
  input wire       i_start,
  input wire       i_stop,
  input wire       i_zero_return_input,
  input wire       i_forward_jog_input,
  input wire       i_reverse_jog_input,
  input wire [2:0] i_stop_mode_parameter,
  input wire       i_pulsing,
  input wire       i_error,
  input wire       i_mcode_valid,
  input wire       o_manual_mode,
  input wire       o_subtask_run,
  input wire       o_start_cmd,
  input wire       o_stop_cmd,
  input wire [2:0] o_stop_mode,
  input wire       o_zero_return_cmd,
  input wire       o_fwd_step,
  input wire       o_fwd_cont,
  input wire       o_rev_step,
  input wire       o_rev_cont,
  input wire       o_ready
);
  localparam MB = DUAL_AXIS ? `PMC_MODE_BIT_DUAL : `PMC_MODE_BIT_SINGLE;
  // Manual request as the sources combine; panel masks the rest
  wire req  = i_panel_manual | i_host_manual_request_flag | (i_input_mode_enable_flag & i_gpi[MB]);
  wire idle = !i_pulsing & !i_error;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  sequence s_stop_held; i_stop [*3]; endsequence
  sequence s_auto_go; $rose(i_start) && !o_manual_mode && !req && !i_stop && !i_mcode_valid; endsequence
  sequence s_man_edge(sig); $rose(sig) && req && !i_stop; endsequence
  ////////////////////////////////////////////////////////////////////////
  chk_mode_prio:
    assert property (!$past(i_rst) |-> o_manual_mode == $past(req)) else $error("mode mismatch");
  chk_ready_track:
    assert property (!$past(i_rst) |-> o_ready == $past(idle)) else $error("ready mismatch");
  chk_stop_pulse:
    assert property ($rose(i_stop) |-> ##2 o_stop_cmd && o_stop_mode == $past(i_stop_mode_parameter)
      ##1 !o_stop_cmd) else $error("bad stop pulse");
  chk_stop_masks:
    assert property (s_stop_held |=> !o_start_cmd && !o_zero_return_cmd && !o_fwd_step && !o_rev_step
      && !o_fwd_cont && !o_rev_cont) else $error("command active under stop");
  chk_start_auto:
    assert property (s_auto_go |-> ##2 o_start_cmd) else $error("start not taken");
  chk_zrn_set:
    assert property (s_man_edge(i_zero_return_input) |-> ##2 o_zero_return_cmd) else $error("no zero return");
  chk_fwd_step:
    assert property (s_man_edge(i_forward_jog_input) |-> ##3 o_fwd_step ##1 !o_fwd_step) else $error("bad fwd step");
  chk_rev_step:
    assert property (s_man_edge(i_reverse_jog_input) |-> ##3 o_rev_step ##1 !o_rev_step) else $error("bad rev step");
  chk_manual_halt:
    assert property (o_manual_mode [*2] |-> !o_subtask_run) else $error("subtask runs in manual");
endmodule
bind pmc_mode_cmd pmc_mode_cmd_checker #(.DUAL_AXIS(DUAL_AXIS)) pmc_mode_cmd_checker_inst (
  .i_core_clk, .i_rst, .i_panel_manual, .i_input_mode_enable_flag, .i_host_manual_request_flag, .i_gpi,
  .i_start, .i_stop, .i_zero_return_input, .i_forward_jog_input, .i_reverse_jog_input, .i_stop_mode_parameter,
  .i_pulsing, .i_error, .i_mcode_valid, .o_manual_mode, .o_subtask_run, .o_start_cmd, .o_stop_cmd,
  .o_stop_mode, .o_zero_return_cmd, .o_fwd_step, .o_fwd_cont, .o_rev_step, .o_rev_cont, .o_ready);

/* tb_pmc_mode_cmd.sv */
// Self-checking bench for the mode arbiter and command inputs
`timescale 1ns/100ps
module tb_pmc_mode_cmd;
  localparam HOLD = 20;
  reg        i_core_clk, i_rst, i_panel_manual, i_input_mode_enable_flag, i_host_manual_request_flag;
  reg        i_start, i_stop, i_zero_return_input, i_forward_jog_input, i_reverse_jog_input;
  reg        i_move_busy, i_error, i_mcode_valid, i_prog_at_end;
  reg  [7:0] i_gpi, i_mcode;
  reg  [2:0] i_stop_mode_parameter;
  wire       i_pulsing, i_zero_return_done, o_manual_mode, o_prog_run, o_subtask_run, o_wait_end;
  wire       o_auto_pulse_en, o_start_cmd, o_stop_cmd, o_zero_return_cmd, o_fwd_step, o_fwd_cont;
  wire       o_rev_step, o_rev_cont, o_ready;
  wire [2:0] o_stop_mode;
  integer    errors, n_tests, k, n;
  // Single-axis variant with a short jog hold to keep the run brief
  pmc_mode_cmd #(.DUAL_AXIS(0), .JOG_HOLD_CYC(HOLD)) pmc_mode_cmd_inst (
    .i_core_clk, .i_rst, .i_panel_manual, .i_input_mode_enable_flag, .i_host_manual_request_flag, .i_gpi,
    .i_start, .i_stop, .i_zero_return_input, .i_forward_jog_input, .i_reverse_jog_input, .i_stop_mode_parameter,
    .i_move_busy, .i_pulsing, .i_error, .i_zero_return_done, .i_mcode_valid, .i_mcode, .i_prog_at_end,
    .o_manual_mode, .o_prog_run, .o_subtask_run, .o_wait_end, .o_auto_pulse_en, .o_start_cmd, .o_stop_cmd,
    .o_stop_mode, .o_zero_return_cmd, .o_fwd_step, .o_fwd_cont, .o_rev_step, .o_rev_cont, .o_ready);
  pmc_gen_model pmc_gen_model_inst (.i_clk(i_core_clk), .i_pulse_en(o_auto_pulse_en),
    .i_zr_cmd(o_zero_return_cmd), .o_pulsing(i_pulsing), .o_zr_done(i_zero_return_done));
  ////////////////////////////////////////////////////////////////////////
  task tk(input integer c); repeat (c) @(negedge i_core_clk); endtask
  task chk(input [7:0] got, input [7:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Steps are one-cycle pulses, so sample every cycle
  task count(input integer c, input rev, output integer p);
    p = 0;
    repeat (c) begin
      @(negedge i_core_clk);
      p = p + (rev ? o_rev_step : o_fwd_step);
    end
  endtask
  task end_sim;
    $display("compares %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {i_panel_manual, i_input_mode_enable_flag, i_host_manual_request_flag, i_start, i_stop} = 5'h00;
    {i_zero_return_input, i_forward_jog_input, i_reverse_jog_input, i_move_busy, i_error} = 5'h00;
    {i_mcode_valid, i_prog_at_end, i_gpi, i_mcode, i_stop_mode_parameter} = 21'h000000;
    errors = 0;
    n_tests = 0;
    i_rst = 1'b1;
    tk(20);
    i_rst = 1'b0;
    tk(3);
    // Every mix of panel, enable, host flag; the unused bit 7 is inverted
    for (k = 0; k < 16; k = k + 1) begin
      {i_panel_manual, i_input_mode_enable_flag, i_host_manual_request_flag} = k[3:1];
      i_gpi = {~k[0], 3'h0, k[0], 3'h0};
      tk(2);
      chk(o_manual_mode, k[3] | k[1] | (k[2] & k[0]));
    end
    $display("mode table done");
    // Manual in mid-move drains before the program halts
    {i_panel_manual, i_input_mode_enable_flag, i_host_manual_request_flag, i_move_busy} = 4'h1;
    tk(3);
    chk({o_prog_run, o_subtask_run}, 2'h3);
    i_panel_manual = 1'b1;
    tk(3);
    chk({o_prog_run, o_subtask_run, o_wait_end}, 3'h5);
    i_move_busy = 1'b0;
    tk(3);
    chk({o_prog_run, o_subtask_run, o_wait_end}, 3'h0);
    $display("drain done");
    // Start in automatic mode, cleared by each halt code
    i_panel_manual = 1'b0;
    for (k = 0; k < 2; k = k + 1) begin
      tk(3);
      i_start = 1'b1;
      tk(2);
      chk(o_start_cmd, 1'b1);
      tk(1);
      chk(o_auto_pulse_en, 1'b1);
      i_mcode = k ? 8'h02 : 8'h00;
      i_mcode_valid = 1'b1;
      tk(3);
      chk(o_start_cmd, 1'b0);
      {i_start, i_mcode_valid} = 2'h0;
    end
    $display("start done");
    // Stop rising with start, every stop mode value
    for (k = 0; k < 8; k = k + 1) begin
      i_stop_mode_parameter = k[2:0];
      {i_start, i_stop} = 2'h3;
      tk(2);
      chk({o_stop_cmd, o_start_cmd, o_stop_mode}, {2'h2, k[2:0]});
      tk(1);
      chk(o_stop_cmd, 1'b0);
      {i_start, i_stop} = 2'h0;
      tk(2);
    end
    $display("stop done");
    // Jog: one step then continuous; stop held blocks jog and zero return
    i_panel_manual = 1'b1;
    for (k = 0; k < 3; k = k + 1) begin
      {i_stop, i_zero_return_input, i_forward_jog_input, i_reverse_jog_input} = k == 1 ? 4'h1 : k ? 4'he : 4'h2;
      count(HOLD + 6, k == 1, n);
      chk(n, k < 2);
      chk({o_fwd_cont, o_rev_cont, o_zero_return_cmd}, k == 0 ? 3'h4 : k == 1 ? 3'h2 : 3'h0);
      {i_stop, i_zero_return_input, i_forward_jog_input, i_reverse_jog_input} = 4'h0;
      tk(3);
      chk({o_fwd_cont, o_rev_cont}, 2'h0);
    end
    $display("jog done");
    // Zero return set, then cleared when the generator reports done
    i_zero_return_input = 1'b1;
    tk(2);
    chk(o_zero_return_cmd, 1'b1);
    for (n = 0; n < 40 && o_zero_return_cmd === 1'b1; n = n + 1) tk(1);
    chk(o_zero_return_cmd, 1'b0);
    if (n == 40) end_sim;
    i_zero_return_input = 1'b0;
    // Error holds ready low
    i_error = 1'b1;
    tk(2);
    chk(o_ready, 1'b0);
    i_error = 1'b0;
    tk(2);
    chk(o_ready, 1'b1);
    $display("zero return and ready done");
    end_sim;
  end
endmodule
